// ---- verilog/ctq_pkg.sv ----
// package: register map, field positions and reset values of the transmit queue block
package ctq_pkg;
  // register byte addresses
  localparam logic [7:0] CTQ_ADDR_BASE_LOW = 8'h00;
  localparam logic [7:0] CTQ_ADDR_CFG_HIGH = 8'h04;
  localparam logic [7:0] CTQ_ADDR_CTL_LOW  = 8'h08;
  localparam logic [7:0] CTQ_ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] CTQ_ADDR_MODE     = 8'h10;
  localparam logic [7:0] CTQ_ADDR_SUMMARY  = 8'h14;
  localparam logic [7:0] CTQ_ADDR_GREQ     = 8'h18;
  // config high fields
  localparam int CTQ_PLSZ_LSB  = 13;
  localparam int CTQ_DEPTH_LSB = 8;
  localparam int CTQ_RETRY_LSB = 5;
  localparam int CTQ_PRIO_LSB  = 0;
  // control low fields
  localparam int CTQ_FLUSH_BIT = 10;
  localparam int CTQ_SEND_BIT  = 9;
  localparam int CTQ_ADV_BIT   = 8;
  localparam int CTQ_DIR_BIT   = 7;
  localparam int CTQ_ATIE_BIT  = 4;
  localparam int CTQ_EIE_BIT   = 2;
  localparam int CTQ_NFIE_BIT  = 0;
  // status fields
  localparam int CTQ_IDX_LSB   = 8;
  localparam int CTQ_ABT_BIT   = 7;
  localparam int CTQ_ARB_BIT   = 6;
  localparam int CTQ_ERR_BIT   = 5;
  localparam int CTQ_ATIF_BIT  = 4;
  localparam int CTQ_EIF_BIT   = 2;
  localparam int CTQ_NFIF_BIT  = 0;
  // mode register fields
  localparam int CTQ_OPMODE_LSB = 0;
  localparam int CTQ_RTEN_BIT   = 4;
  // values after reset and codes
  localparam logic [2:0] CTQ_MODE_CONFIG   = 3'h4;
  localparam logic [2:0] CTQ_MODE_RST      = 3'h4;
  localparam logic [1:0] CTQ_RETRY_RST     = 2'h3;
  localparam logic [1:0] CTQ_RETRY_NONE    = 2'h0;
  localparam logic [1:0] CTQ_RETRY_THREE   = 2'h1;
  localparam logic [1:0] CTQ_THREE_TRIES   = 2'h3;
  localparam logic [15:0] CTQ_BASE_MASK    = 16'hFFFC;
  localparam int CTQ_FLUSH_CYCLES          = 2;
  // outcome codes from the protocol engine
  typedef enum logic [1:0] {CTQ_RES_OK, CTQ_RES_ARB, CTQ_RES_ERR} ctq_result_t;
endpackage : ctq_pkg

// ---- verilog/ctq_ahb_slave.sv ----
// AHB-Lite slave front end: captures address phase, issues one-cycle register strobes
`timescale 1ns/10ps
module ctq_ahb_slave
  import ctq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             wr_stb,
  output logic             rd_phase,
  output logic [7:0]       reg_addr
);
  logic       pend_wr_r;
  logic       pend_rd_r;
  logic [7:0] addr_r;

  // address phase capture; every access finishes in its first data cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_wr_r <= 1'b0;
      pend_rd_r <= 1'b0;
      addr_r    <= 8'h00;
    end
    else if (hready)
    begin
      pend_wr_r <= hsel & htrans[1] & hwrite;
      pend_rd_r <= hsel & htrans[1] & ~hwrite;
      addr_r    <= haddr[7:0];
    end
  end

  assign wr_stb   = pend_wr_r;
  assign rd_phase = pend_rd_r;
  assign reg_addr = addr_r;
endmodule : ctq_ahb_slave

// ---- verilog/ctq_queue_ctrl.sv ----
// transmit queue control and status registers with their AHB-Lite access
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module ctq_queue_ctrl
  import ctq_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              eng_done,
  input  wire ctq_pkg::ctq_result_t eng_result,
  input  wire logic              eng_abort_done,
  output logic                   eng_send,
  output logic                   eng_abort,
  output logic [4:0]             eng_slot,
  output logic [4:0]             eng_priority,
  output logic [6:0]             eng_payload_bytes,
  output logic [15:0]            eng_base_low,
  output logic                   tx_irq_pending
);
  import ctq_pkg::*;
  logic        wr_stb, rd_phase, unused_ok;
  logic [7:0]  reg_addr;
  logic [15:0] wd, base_r;
  logic [2:0]  plsz_r, opmode_r;
  logic [4:0]  depth_r, prio_r, head_r, tail_r;
  logic [1:0]  retry_r, flush_cnt_r, tries_r;
  logic [5:0]  count_r;
  logic [6:0]  bytes_r;
  logic [31:0] rdata_r;
  logic        rten_r, flush_r, send_r, abort_r, atie_r, eie_r, nfie_r, irq_r;
  logic        abt_r, arb_r, err_r, atif_r;
  logic        w_base, w_cfg, w_ctl, w_sta, w_mode, w_greq;
  logic        advance, sent_ok, failed, exhaust, empty, not_full;

  // payload code to byte count
  function automatic logic [6:0] ctq_bytes(input logic [2:0] code);
    case (code)
      3'h0: ctq_bytes = 7'd8;
      3'h1: ctq_bytes = 7'd12;
      3'h2: ctq_bytes = 7'd16;
      3'h3: ctq_bytes = 7'd20;
      3'h4: ctq_bytes = 7'd24;
      3'h5: ctq_bytes = 7'd32;
      3'h6: ctq_bytes = 7'd48;
      default: ctq_bytes = 7'd64;
    endcase
  endfunction : ctq_bytes

  // wrap a slot pointer at the configured depth
  function automatic logic [4:0] ctq_wrap(input logic [4:0] p, input logic [4:0] d);
    ctq_wrap = (p == d) ? 5'h00 : 5'(p + 5'h01);
  endfunction : ctq_wrap

  ctq_ahb_slave u_slave (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .hsel     (hsel),
    .haddr    (haddr),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .hready   (hready),
    .wr_stb   (wr_stb),
    .rd_phase (rd_phase),
    .reg_addr (reg_addr)
  );

  // register write decode; hsize ignored since only word transfers occur
  assign wd     = hwdata[15:0];
  assign w_base = wr_stb && (reg_addr == CTQ_ADDR_BASE_LOW);
  assign w_cfg  = wr_stb && (reg_addr == CTQ_ADDR_CFG_HIGH);
  assign w_ctl  = wr_stb && (reg_addr == CTQ_ADDR_CTL_LOW);
  assign w_sta  = wr_stb && (reg_addr == CTQ_ADDR_STATUS);
  assign w_mode = wr_stb && (reg_addr == CTQ_ADDR_MODE);
  assign w_greq = wr_stb && (reg_addr == CTQ_ADDR_GREQ);

  // queue state terms
  assign empty    = (count_r == 6'h00);
  assign not_full = (count_r != {1'b0, depth_r} + 6'h01);
  assign advance  = w_ctl && wd[CTQ_ADV_BIT] && not_full && !flush_r;
  assign sent_ok  = eng_done && (eng_result == CTQ_RES_OK);
  assign failed   = eng_done && (eng_result != CTQ_RES_OK);
  // retries used up: none allowed, or three retries after four tries
  assign exhaust  = failed && rten_r && ((retry_r == CTQ_RETRY_NONE) ||
                    ((retry_r == CTQ_RETRY_THREE) && (tries_r == CTQ_THREE_TRIES)));

  // base address low half, two low bits held at zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      base_r <= 16'h0000;
    else if (w_base)
      base_r <= wd & CTQ_BASE_MASK;
  end

  // operating mode and controller-wide retry enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      opmode_r <= CTQ_MODE_RST;
      rten_r   <= 1'b0;
    end
    else if (w_mode)
    begin
      opmode_r <= wd[CTQ_OPMODE_LSB +: 3];
      rten_r   <= wd[CTQ_RTEN_BIT];
    end
  end

  // queue configuration; size fields locked outside configuration mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      plsz_r  <= 3'h0;
      depth_r <= 5'h00;
      retry_r <= CTQ_RETRY_RST;
      prio_r  <= 5'h00;
    end
    else if (w_cfg)
    begin
      if (opmode_r == CTQ_MODE_CONFIG)
      begin
        plsz_r  <= wd[CTQ_PLSZ_LSB +: 3];
        depth_r <= wd[CTQ_DEPTH_LSB +: 5];
      end
      retry_r <= wd[CTQ_RETRY_LSB +: 2];
      prio_r  <= wd[CTQ_PRIO_LSB +: 5];
    end
  end

  // interrupt enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      atie_r <= 1'b0;
      eie_r  <= 1'b0;
      nfie_r <= 1'b0;
    end
    else if (w_ctl)
    begin
      atie_r <= wd[CTQ_ATIE_BIT];
      eie_r  <= wd[CTQ_EIE_BIT];
      nfie_r <= wd[CTQ_NFIE_BIT];
    end
  end

  // flush: held a fixed number of cycles, then cleared by hardware
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flush_r     <= 1'b0;
      flush_cnt_r <= 2'h0;
    end
    else if (flush_r)
    begin
      flush_cnt_r <= 2'(flush_cnt_r + 2'h1);
      if (flush_cnt_r == 2'(CTQ_FLUSH_CYCLES - 1))
        flush_r <= 1'b0;
    end
    else if (w_ctl && wd[CTQ_FLUSH_BIT])
    begin
      flush_r     <= 1'b1;
      flush_cnt_r <= 2'h0;
    end
  end

  // send request and abort handshake
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      send_r  <= 1'b0;
      abort_r <= 1'b0;
    end
    else if (flush_r)
    begin
      send_r  <= 1'b0;
      abort_r <= 1'b0;
    end
    else
    begin
      if ((w_ctl && wd[CTQ_SEND_BIT]) || (w_greq && wd[0]))
        send_r <= 1'b1;
      else if (w_ctl && !wd[CTQ_SEND_BIT] && send_r)
      begin
        send_r  <= 1'b0;
        abort_r <= 1'b1;
      end
      else if (sent_ok && (count_r == 6'h01) && !advance)
        send_r <= 1'b0;
      if (eng_abort_done)
        abort_r <= 1'b0;
    end
  end

  // head, tail and occupancy; tail moves on success or exhaustion
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      head_r  <= 5'h00;
      tail_r  <= 5'h00;
      count_r <= 6'h00;
    end
    else if (flush_r)
    begin
      head_r  <= 5'h00;
      tail_r  <= 5'h00;
      count_r <= 6'h00;
    end
    else
    begin
      if (advance)
        head_r <= ctq_wrap(head_r, depth_r);
      if ((sent_ok || exhaust) && !empty)
        tail_r <= ctq_wrap(tail_r, depth_r);
      if (advance && !((sent_ok || exhaust) && !empty))
        count_r <= 6'(count_r + 6'h01);
      else if (!advance && (sent_ok || exhaust) && !empty)
        count_r <= 6'(count_r - 6'h01);
    end
  end

  // outcome of the last message and attempt counting
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      abt_r   <= 1'b0;
      arb_r   <= 1'b0;
      err_r   <= 1'b0;
      tries_r <= 2'h0;
    end
    else if (flush_r)
    begin
      abt_r   <= 1'b0;
      arb_r   <= 1'b0;
      err_r   <= 1'b0;
      tries_r <= 2'h0;
    end
    else if (eng_abort_done)
      abt_r <= 1'b1;
    else if (eng_done)
    begin
      abt_r   <= (sent_ok || exhaust) ? exhaust : abt_r;
      arb_r   <= (eng_result == CTQ_RES_ARB);
      err_r   <= (eng_result == CTQ_RES_ERR);
      tries_r <= (sent_ok || exhaust) ? 2'h0 : 2'(tries_r + 2'h1);
    end
  end

  // attempts-exhausted flag: set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      atif_r <= 1'b0;
    else if (exhaust)
      atif_r <= 1'b1;
    else if (w_sta && !wd[CTQ_ATIF_BIT])
      atif_r <= 1'b0;
  end

  // pending summary bit and registered engine outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_r   <= 1'b0;
      bytes_r <= 7'd8;
    end
    else
    begin
      irq_r   <= (atif_r & atie_r) | (empty & eie_r) | (not_full & nfie_r);
      bytes_r <= ctq_bytes(plsz_r);
    end
  end

  // read data, registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_r <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      rdata_r <= 32'h0000_0000;
      if (haddr[7:0] == CTQ_ADDR_BASE_LOW)
        rdata_r[15:0] <= base_r;
      else if (haddr[7:0] == CTQ_ADDR_CFG_HIGH)
        rdata_r[15:0] <= {plsz_r, depth_r, 1'b0, retry_r, prio_r};
      else if (haddr[7:0] == CTQ_ADDR_CTL_LOW)
        rdata_r[15:0] <= {5'h00, flush_r, send_r, 1'b0, 1'b1, 2'h0, atie_r, 1'b0,
                          eie_r, 1'b0, nfie_r};
      else if (haddr[7:0] == CTQ_ADDR_STATUS)
        rdata_r[15:0] <= {3'h0, tail_r, abt_r, arb_r, err_r, atif_r, 1'b0,
                          empty, 1'b0, not_full};
      else if (haddr[7:0] == CTQ_ADDR_MODE)
        rdata_r[15:0] <= {11'h000, rten_r, 1'b0, opmode_r};
      else if (haddr[7:0] == CTQ_ADDR_SUMMARY)
        rdata_r[15:0] <= {15'h0000, irq_r};
      else if (haddr[7:0] == CTQ_ADDR_GREQ)
        rdata_r[15:0] <= {15'h0000, send_r};
    end
  end

  // engine-facing outputs, each from a flip-flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      eng_send     <= 1'b0;
      eng_abort    <= 1'b0;
      eng_slot     <= 5'h00;
      eng_priority <= 5'h00;
      eng_base_low <= 16'h0000;
    end
    else
    begin
      eng_send     <= send_r & ~empty & ~flush_r;
      eng_abort    <= abort_r & ~eng_abort_done; // drop with the engine's done pulse
      eng_slot     <= tail_r;
      eng_priority <= prio_r;
      eng_base_low <= base_r;
    end
  end

  assign hrdata            = rdata_r;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign eng_payload_bytes = bytes_r;
  assign tx_irq_pending    = irq_r;
  // rd_phase, hsize and the head pointer are kept for completeness but not read
  assign unused_ok = rd_phase | (|hsize) | (|hwdata[31:16]) | (|haddr[31:8]) | (|head_r);
endmodule : ctq_queue_ctrl

// ---- test/ctq_queue_ctrl_assertions.sv ----
// checker: port-level properties of the transmit queue control block
`timescale 1ns/10ps
module ctq_queue_ctrl_assertions
  import ctq_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        eng_abort,
  input wire logic        eng_abort_done,
  input wire logic [4:0]  eng_slot,
  input wire logic [6:0]  eng_payload_bytes,
  input wire logic [15:0] eng_base_low
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rq;
  // a read address phase accepted at this edge
  assign rq = hsel && htrans[1] && hready && !hwrite;
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave response not OKAY");
  no_wait_a: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  payload_bytes_a: assert property (eng_payload_bytes inside
    {7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40})
    else $error("payload byte count outside table");
  base_align_a: assert property (eng_base_low[1:0] == 2'h0)
    else $error("base address not word aligned");
  abort_hold_a: assert property (eng_abort && !eng_abort_done |=> eng_abort)
    else $error("abort dropped before engine finished");
  slot_step_a: assert property (!$stable(eng_slot) |->
    eng_slot == $past(eng_slot) + 5'h01 || eng_slot == 5'h00)
    else $error("slot index jumped");
  status_gaps_a: assert property (rq && haddr[7:0] == CTQ_ADDR_STATUS |=>
    hrdata[31:13] == 19'h0 && !hrdata[3] && !hrdata[1])
    else $error("status unused bits not zero");
  ctl_dir_a: assert property (rq && haddr[7:0] == CTQ_ADDR_CTL_LOW |=>
    hrdata[7] && hrdata[6:5] == 2'h0 && hrdata[31:11] == 21'h0)
    else $error("control direction or unused bits wrong");
  cfg_gap_a: assert property (rq && haddr[7:0] == CTQ_ADDR_CFG_HIGH |=>
    !hrdata[7] && hrdata[31:16] == 16'h0)
    else $error("config unused bits not zero");
  unmapped_zero_a: assert property (rq && haddr[7:0] == 8'h1C |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : ctq_queue_ctrl_assertions

bind ctq_queue_ctrl ctq_queue_ctrl_assertions u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .eng_abort(eng_abort), .eng_abort_done(eng_abort_done),
  .eng_slot(eng_slot), .eng_payload_bytes(eng_payload_bytes),
  .eng_base_low(eng_base_low));

// ---- test/ctq_eng_model.sv ----
// partner model: protocol engine that runs attempts and aborts
`timescale 1ns/10ps
module ctq_eng_model
  import ctq_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 eng_send,
  input  wire logic                 eng_abort,
  input  wire logic                 hold,
  input  wire ctq_pkg::ctq_result_t res,
  output logic                      eng_done,
  output ctq_pkg::ctq_result_t      eng_result,
  output logic                      eng_abort_done
);
  logic [3:0] cnt_r;
  logic       fin;
  // an attempt ends after eight cycles unless held or aborted
  assign fin = eng_send && !hold && !eng_abort && cnt_r == 4'h7;
  // attempt and abort timing; result is scrambled outside the done pulse
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt_r <= 4'h0;
      eng_done <= 1'b0;
      eng_abort_done <= 1'b0;
      eng_result <= CTQ_RES_ERR;
    end
    else
    begin
      cnt_r <= ((eng_send && !hold) || eng_abort) && cnt_r != 4'h7 ? cnt_r + 4'h1 : 4'h0;
      eng_done <= fin;
      eng_abort_done <= eng_abort && cnt_r == 4'h2;
      eng_result <= fin ? res : ctq_result_t'(~cnt_r[1:0]);
    end
endmodule : ctq_eng_model

// ---- test/canfd_transmit_queue_ctrl_tb_top.sv ----
// testbench: register-level tests of the transmit queue control block
`timescale 1ns/10ps
module canfd_transmit_queue_ctrl_tb_top;
  import ctq_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, hold;
  logic        eng_done, eng_abort_done, eng_send, eng_abort, tx_irq_pending;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  eng_slot, eng_priority;
  logic [6:0]  eng_payload_bytes;
  logic [15:0] eng_base_low;
  logic [31:0] haddr, hwdata, hrdata, rd;
  ctq_result_t eng_result, res;
  int          num_errors, cmp_count, i;
  int          pl[8] = '{8, 12, 16, 20, 24, 32, 48, 64};

  ctq_queue_ctrl uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eng_done(eng_done),
    .eng_result(eng_result), .eng_abort_done(eng_abort_done), .eng_send(eng_send),
    .eng_abort(eng_abort), .eng_slot(eng_slot), .eng_priority(eng_priority),
    .eng_payload_bytes(eng_payload_bytes), .eng_base_low(eng_base_low),
    .tx_irq_pending(tx_irq_pending));
  ctq_eng_model u_eng (
    .hclk(hclk), .hresetn(hresetn), .eng_send(eng_send), .eng_abort(eng_abort),
    .hold(hold), .res(res), .eng_done(eng_done), .eng_result(eng_result),
    .eng_abort_done(eng_abort_done));

  // free-running clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // wait for an edge with ready high, bounded
  task automatic rdy;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    num_errors++;
    test_done();
  endtask : rdy

  // one single AHB-Lite word transfer
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask : rc

  // read until the masked bits match, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int n = 0; n < 100; n++)
    begin
      xfer(a, 1'b0, 32'h0);
      if ((rd & m) === e)
        break;
    end
    chk(rd & m, e);
  endtask : poll

  // main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hold = 1'b0;
    res = CTQ_RES_OK;
    num_errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rc(CTQ_ADDR_CFG_HIGH, 32'h0060);
    rc(CTQ_ADDR_CTL_LOW, 32'h0080);
    rc(CTQ_ADDR_STATUS, 32'h0005);
    rc(CTQ_ADDR_MODE, 32'h0004);
    rc(CTQ_ADDR_SUMMARY, 32'h0);
    rc(8'h1C, 32'h0);
    wr(CTQ_ADDR_BASE_LOW, 32'hFFFF_FFFF);
    rc(CTQ_ADDR_BASE_LOW, 32'h0000_FFFC);
    chk(32'(eng_base_low), 32'hFFFC);
    $display("test reset and base done");
    for (i = 0; i < 8; i++)
    begin
      wr(CTQ_ADDR_CFG_HIGH, (32'(i) << CTQ_PLSZ_LSB) | 32'h0160);
      rc(CTQ_ADDR_CFG_HIGH, (32'(i) << CTQ_PLSZ_LSB) | 32'h0160);
      chk(32'(eng_payload_bytes), pl[i]);
    end
    wr(CTQ_ADDR_CFG_HIGH, 32'h017F);
    wr(CTQ_ADDR_MODE, 32'h0);
    wr(CTQ_ADDR_CFG_HIGH, 32'hFF7F);
    rc(CTQ_ADDR_CFG_HIGH, 32'h017F);
    chk(32'(eng_priority), 32'h1F);
    $display("test config done");
    for (i = 0; i < 3; i++)
      wr(CTQ_ADDR_CTL_LOW, 32'h0100);
    rc(CTQ_ADDR_STATUS, 32'h0000);
    wr(CTQ_ADDR_CTL_LOW, 32'h0200);
    poll(CTQ_ADDR_CTL_LOW, 32'h0200, 32'h0);
    rc(CTQ_ADDR_STATUS, 32'h0005);
    chk(32'(eng_slot), 32'h0);
    $display("test fill and send done");
    wr(CTQ_ADDR_MODE, 32'h0010);
    for (i = 0; i < 2; i++)
    begin
      res <= i ? CTQ_RES_ERR : CTQ_RES_ARB;
      wr(CTQ_ADDR_CFG_HIGH, i ? 32'h011F : 32'h013F);
      wr(CTQ_ADDR_CTL_LOW, 32'h0110);
      rc(CTQ_ADDR_STATUS, 32'h0001);
      wr(CTQ_ADDR_CTL_LOW, 32'h0210);
      poll(CTQ_ADDR_STATUS, 32'h0010, 32'h0010);
      rc(CTQ_ADDR_STATUS, i ? 32'h01B5 : 32'h01D5);
      chk(32'(tx_irq_pending), 32'h1);
      wr(CTQ_ADDR_STATUS, 32'h0);
      rc(CTQ_ADDR_STATUS, i ? 32'h01A5 : 32'h01C5);
      chk(32'(tx_irq_pending), 32'h0);
      // request stays set after exhaustion: keep it set so the flush is not also an abort
      wr(CTQ_ADDR_CTL_LOW, 32'h0600);
      poll(CTQ_ADDR_CTL_LOW, 32'h0600, 32'h0);
    end
    $display("test exhaustion done");
    hold <= 1'b1;
    wr(CTQ_ADDR_CTL_LOW, 32'h0100);
    wr(CTQ_ADDR_GREQ, 32'h1);
    rc(CTQ_ADDR_CTL_LOW, 32'h0280);
    wr(CTQ_ADDR_GREQ, 32'h0);
    rc(CTQ_ADDR_GREQ, 32'h1);
    wr(CTQ_ADDR_CTL_LOW, 32'h0);
    poll(CTQ_ADDR_STATUS, 32'h0080, 32'h0080);
    hold <= 1'b0;
    wr(CTQ_ADDR_CTL_LOW, 32'h0400);
    poll(CTQ_ADDR_CTL_LOW, 32'h0400, 32'h0);
    rc(CTQ_ADDR_STATUS, 32'h0005);
    $display("test abort done");
    wr(CTQ_ADDR_CTL_LOW, 32'h0004);
    rc(CTQ_ADDR_STATUS, 32'h0005);
    chk(32'(tx_irq_pending), 32'h1);
    rc(CTQ_ADDR_SUMMARY, 32'h1);
    $display("test interrupt enables done");
    test_done();
  end
endmodule : canfd_transmit_queue_ctrl_tb_top
